// ---- core/csr_cfg.svh ----
// Register map, field positions, reset values and timing counts
`ifndef CSR_CFG_SVH
`define CSR_CFG_SVH

// Register indices, byte address is four times the index
`define CSR_OSCCTL_IDX      8'hdb
`define CSR_CLKCTL_IDX      8'hdc
`define CSR_OSCCTL_ADDR     {2'b00, `CSR_OSCCTL_IDX, 2'b00}
`define CSR_CLKCTL_ADDR     {2'b00, `CSR_CLKCTL_IDX, 2'b00}

// Field positions
`define CSR_MAIN_OSC_OFF_BIT      0
`define CSR_ADCSLOW_BIT     0
`define CSR_ST_MAIN_BIT     8
`define CSR_ST_AUX_BIT      9
`define CSR_ST_RST_BIT      10

// Reset values
`define CSR_MAIN_OSC_OFF_RST      1'b0
`define CSR_ADCSLOW_RST     1'b0

// AXI responses
`define CSR_RESP_OKAY       2'b00
`define CSR_RESP_SLVERR     2'b10

// Fixed divider ratios of the internal clock
`define CSR_DIV_TIMER       12
`define CSR_DIV_CORE        13
`define CSR_DIV_ADC_FAST    6
`define CSR_DIV_ADC_SLOW    12

// Internal clock cycles between external release and internal release
`define CSR_RST_DELAY       2048

// Reference clock 25 MHz
`define CSR_REF_MHZ         25
// Main edge absence that counts as a missing edge (longest, rounds down)
`define CSR_MISS_NS         1000
`define CSR_MISS_CYC        ((`CSR_MISS_NS * `CSR_REF_MHZ) / 1000)
// Shortest internal clock period under the safeguard (rounds up)
`define CSR_SG_MIN_NS       125
`define CSR_SG_MIN_CYC      ((`CSR_SG_MIN_NS * `CSR_REF_MHZ + 999) / 1000)

`endif

// ---- core/csr_clk_div.sv ----
// Fixed-ratio divider of the internal clock tick
`timescale 1ns/100ps
module csr_clk_div #(
	parameter int RATIO = 12
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	// Tick in and divided pulse out
	input  wire logic run,
	input  wire logic tickIn,
	output logic      tickOut
);
	import csr_pkg::*;

	typedef struct packed {
		logic [3:0] cnt;
		logic       pulse;
	} csr_div_st_t;

	csr_div_st_t st;
	csr_div_st_t next_st;

	always_comb begin
		next_st = st;
		next_st.pulse = 1'b0;
		if (!run) begin
			next_st.cnt = 4'h0;
		end else if (tickIn) begin
			if (st.cnt == 4'(RATIO - 1)) begin
				next_st.cnt = 4'h0;
				next_st.pulse = 1'b1;
			end else begin
				next_st.cnt = st.cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tickOut = st.pulse;

	a_div_ratio: assert property (@(posedge ref_clk) disable iff (!rst_n)
		st.pulse |-> $past(tickIn) && $past(st.cnt) == 4'(RATIO - 1))
		else $error("divider pulse without full count");
endmodule : csr_clk_div

// ---- core/csr_osc_mon.sv ----
// Clock source selection, missing-edge fallback and safeguard filter
`timescale 1ns/100ps
`include "csr_cfg.svh"
module csr_osc_mon (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	// Oscillator levels and controls
	input  wire logic mainOscIn,
	input  wire logic auxOscIn,
	input  wire logic mainOscOn,
	input  wire logic sgEnable,
	// Internal clock tick and source state
	output logic      intTick,
	output logic      mainRunning,
	output logic      auxEnable
);
	import csr_pkg::*;

	typedef struct packed {
		logic       mainPrev;
		logic       auxPrev;
		csr_src_t   src;
		logic [7:0] missCnt;
		logic [7:0] gapCnt;
		logic       tick;
		logic       auxOn;
	} csr_mon_st_t;

	csr_mon_st_t st;
	csr_mon_st_t next_st;
	logic        mainEdge;
	logic        auxEdge;
	logic        rawTick;

	assign mainEdge = mainOscIn && !st.mainPrev && mainOscOn;
	assign auxEdge  = auxOscIn && !st.auxPrev && st.auxOn;

	always_comb begin
		next_st = st;
		next_st.mainPrev = mainOscIn;
		next_st.auxPrev = auxOscIn;
		next_st.tick = 1'b0;
		rawTick = 1'b0;
		if (mainEdge || st.missCnt == 8'(`CSR_MISS_CYC)) begin
			next_st.missCnt = mainEdge ? 8'h0 : st.missCnt;
		end else begin
			next_st.missCnt = st.missCnt + 8'h1;
		end
		case (st.src)
			CSR_SRC_MAIN: begin
				rawTick = mainEdge;
				// Fallback exists only with the safeguard option
				if (sgEnable && !mainEdge
					&& st.missCnt == 8'(`CSR_MISS_CYC)) begin
					next_st.src = CSR_SRC_MISSING;
					next_st.auxOn = 1'b1;
				end
			end
			CSR_SRC_MISSING: begin
				// First aux period is swallowed, no short pulse reaches core
				if (mainEdge) begin
					next_st.src = CSR_SRC_MAIN;
					next_st.auxOn = 1'b0;
				end else if (auxEdge) begin
					next_st.src = CSR_SRC_AUX;
				end
			end
			CSR_SRC_AUX: begin
				rawTick = auxEdge;
				if (mainEdge) begin
					next_st.src = CSR_SRC_MAIN;
					next_st.auxOn = 1'b0;
				end
			end
			default: begin
				next_st.src = CSR_SRC_MAIN;
			end
		endcase
		if (st.gapCnt != 8'hff) begin
			next_st.gapCnt = st.gapCnt + 8'h1;
		end
		// Ticks closer than the safeguard period are dropped as spikes
		if (rawTick && (!sgEnable
			|| st.gapCnt >= 8'(`CSR_SG_MIN_CYC - 1))) begin
			next_st.tick = 1'b1;
			next_st.gapCnt = 8'h0;
		end
		if (!sgEnable) begin
			next_st.auxOn = 1'b0;
			next_st.src = CSR_SRC_MAIN;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st <= '{default: '0, src: CSR_SRC_MAIN};
		end else begin
			st <= next_st;
		end
	end

	assign intTick     = st.tick;
	assign mainRunning = (st.src == CSR_SRC_MAIN);
	assign auxEnable   = st.auxOn;

	a_sg_gap_min: assert property (@(posedge ref_clk) disable iff (!rst_n)
		sgEnable && st.tick |=> !st.tick ##1 !st.tick)
		else $error("safeguard passed two ticks too close");
	a_aux_off_main: assert property (@(posedge ref_clk) disable iff (!rst_n)
		st.src == CSR_SRC_AUX && mainEdge |=> !st.auxOn)
		else $error("aux oscillator left on after main restart");
	a_aux_no_sg: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!sgEnable |=> !st.auxOn)
		else $error("aux oscillator on without safeguard option");
endmodule : csr_osc_mon

// ---- core/csr_pkg.sv ----
// Types shared by the clock and reset controller
package csr_pkg;
	typedef enum logic [1:0] {
		CSR_ILEN_2,
		CSR_ILEN_4,
		CSR_ILEN_5
	} csr_ilen_t;

	typedef enum logic [1:0] {
		CSR_SRC_MAIN,
		CSR_SRC_MISSING,
		CSR_SRC_AUX
	} csr_src_t;
endpackage : csr_pkg

// ---- core/csr_top.sv ----
// Clock and reset controller with AXI4-Lite register access
//
// Contract
// - Timer/watchdog tick /12, core tick /13
// - Converter tick is internal clock /6 or /12
// - Instructions last two, four or five machine cycles
// - Safeguard plus off bit stops main, starts aux
// - Main restarts on clearing off bit or reset
// - Aux starts one period after missing main edge
// - Aux switches off once main runs again
// - Aux clock runs all code, only slower
// - Power-on delay counts aux ticks until main runs (code counts intTick of the active source, main ticks while main runs)
// - Control bit 0 low runs main, high stops
// - Safeguard option drops spikes, caps internal rate
// - Reset from pin, power-on or watchdog
// - Pin reset in any mode, held while low
// - Short pin pulses still give full reset
// - Run/wait reset: stop, pull up, restart main
// - Stop reset: start oscillator, pull up pins
// - Power-on: held, pulled up, delay then run
// - Internal release 2048 internal ticks after release
// - Watchdog reset restarts like pin reset
// - Safeguard on when option bit high
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "csr_cfg.svh"
module csr_top (
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	// Oscillators and option
	input  wire logic              mainOscIn,
	input  wire logic              auxOscIn,
	input  wire logic              safeguardOptionBit,
	output logic                   mainOscEnable,
	output logic                   auxOscEnable,
	// Reset sources and results
	input  wire logic              extRst_n,
	input  wire logic              porReq,
	input  wire logic              wdgRstReq,
	output logic                   intReset,
	output logic                   ioPullup,
	// Derived ticks
	input  wire csr_pkg::csr_ilen_t instrLen,
	output logic                   timerTick,
	output logic                   coreTick,
	output logic                   adcTick,
	output logic                   instrEnd,
	// AXI4-Lite slave
	input  wire logic [11:0]       s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [11:0]       s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);
	import csr_pkg::*;

	typedef struct packed {
		logic        awHeld;
		logic [11:0] awAddr;
		logic        wHeld;
		logic [31:0] wData;
		logic [3:0]  wStrb;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        main_osc_off;
		logic        adcSlow;
		logic        intReset;
		logic [10:0] rstCnt;
		logic        mainOscEnable;
		logic        ioPullup;
		logic [2:0]  mcCnt;
		logic [2:0]  mcTarget;
		logic        instrEnd;
	} csr_top_st_t;

	csr_top_st_t st;
	csr_top_st_t next_st;
	logic        intTick;
	logic        mainRunning;
	logic        auxEnable;
	logic        rstSource;
	logic        adcFast;
	logic        adcSlowTick;
	logic        awTake;
	logic        wTake;
	logic        arTake;
	logic        doWrite;
	logic        timerPulse;
	logic        corePulse;

	function automatic logic [2:0] csr_len(input csr_ilen_t len);
		case (len)
			CSR_ILEN_2: csr_len = 3'd2;
			CSR_ILEN_4: csr_len = 3'd4;
			CSR_ILEN_5: csr_len = 3'd5;
			default:    csr_len = 3'd2;
		endcase
	endfunction : csr_len

	csr_osc_mon u_osc_mon (
		.ref_clk     (ref_clk),
		.rst_n       (rst_n),
		.mainOscIn   (mainOscIn),
		.auxOscIn    (auxOscIn),
		.mainOscOn   (st.mainOscEnable),
		.sgEnable    (safeguardOptionBit),
		.intTick     (intTick),
		.mainRunning (mainRunning),
		.auxEnable   (auxEnable)
	);

	// Dividers stay idle during internal reset so they start aligned
	csr_clk_div #(.RATIO(`CSR_DIV_TIMER)) u_div_timer (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.run     (!st.intReset),
		.tickIn  (intTick),
		.tickOut (timerPulse)
	);

	csr_clk_div #(.RATIO(`CSR_DIV_CORE)) u_div_core (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.run     (!st.intReset),
		.tickIn  (intTick),
		.tickOut (corePulse)
	);

	csr_clk_div #(.RATIO(`CSR_DIV_ADC_FAST)) u_div_adc_fast (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.run     (!st.intReset && !st.adcSlow),
		.tickIn  (intTick),
		.tickOut (adcFast)
	);

	csr_clk_div #(.RATIO(`CSR_DIV_ADC_SLOW)) u_div_adc_slow (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.run     (!st.intReset && st.adcSlow),
		.tickIn  (intTick),
		.tickOut (adcSlowTick)
	);

	// Watchdog request takes the same path as the pin
	assign rstSource = !extRst_n || porReq || wdgRstReq;

	assign awTake  = s_axi_awvalid && st.awready;
	assign wTake   = s_axi_wvalid && st.wready;
	assign arTake  = s_axi_arvalid && st.arready;
	assign doWrite = (st.awHeld || awTake) && (st.wHeld || wTake)
		&& !st.bvalid;

	always_comb begin
		next_st = st;
		next_st.instrEnd = 1'b0;

		// Write address and data accepted in either order
		if (awTake) begin
			next_st.awHeld = 1'b1;
			next_st.awAddr = s_axi_awaddr;
		end
		if (wTake) begin
			next_st.wHeld = 1'b1;
			next_st.wData = s_axi_wdata;
			next_st.wStrb = s_axi_wstrb;
		end
		if (doWrite) begin
			next_st.awHeld = 1'b0;
			next_st.wHeld = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = `CSR_RESP_OKAY;
			case (awTake ? s_axi_awaddr : st.awAddr)
				`CSR_OSCCTL_ADDR: begin
					// Only bit 0 is stored, upper bits read back zero
					if (wTake ? s_axi_wstrb[0] : st.wStrb[0]) begin
						next_st.main_osc_off = wTake
							? s_axi_wdata[`CSR_MAIN_OSC_OFF_BIT]
							: st.wData[`CSR_MAIN_OSC_OFF_BIT];
					end
				end
				`CSR_CLKCTL_ADDR: begin
					if (wTake ? s_axi_wstrb[0] : st.wStrb[0]) begin
						next_st.adcSlow = wTake
							? s_axi_wdata[`CSR_ADCSLOW_BIT]
							: st.wData[`CSR_ADCSLOW_BIT];
					end
				end
				default: begin
					next_st.bresp = `CSR_RESP_SLVERR;
				end
			endcase
		end else if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end

		if (arTake) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = `CSR_RESP_OKAY;
			next_st.rdata = 32'h0;
			case (s_axi_araddr)
				`CSR_OSCCTL_ADDR: begin
					next_st.rdata[`CSR_MAIN_OSC_OFF_BIT] = st.main_osc_off;
				end
				`CSR_CLKCTL_ADDR: begin
					next_st.rdata[`CSR_ADCSLOW_BIT] = st.adcSlow;
					next_st.rdata[`CSR_ST_MAIN_BIT] = mainRunning;
					next_st.rdata[`CSR_ST_AUX_BIT] = auxEnable;
					next_st.rdata[`CSR_ST_RST_BIT] = st.intReset;
				end
				default: begin
					next_st.rresp = `CSR_RESP_SLVERR;
				end
			endcase
		end else if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end

		// Reset sequencing, counted in internal clock ticks
		if (rstSource) begin
			next_st.intReset = 1'b1;
			next_st.rstCnt = 11'h0;
		end else if (st.intReset && intTick) begin
			// A short pulse still gets the full count
			if (st.rstCnt == 11'(`CSR_RST_DELAY - 1)) begin
				next_st.intReset = 1'b0;
			end else begin
				next_st.rstCnt = st.rstCnt + 11'h1;
			end
		end
		if (next_st.intReset) begin
			next_st.main_osc_off = `CSR_MAIN_OSC_OFF_RST;
			next_st.adcSlow = `CSR_ADCSLOW_RST;
		end
		next_st.ioPullup = next_st.intReset;
		// Off bit acts only with the safeguard, so a clock always exists
		next_st.mainOscEnable = !(next_st.main_osc_off
			&& safeguardOptionBit);

		// Machine cycles per instruction, none while in reset
		if (next_st.intReset) begin
			next_st.mcCnt = 3'h0;
			next_st.mcTarget = 3'h0;
		end else if (corePulse) begin
			if (st.mcCnt == 3'h0) begin
				next_st.mcTarget = csr_len(instrLen);
			end
			if (st.mcCnt + 3'h1 == (st.mcCnt == 3'h0
				? csr_len(instrLen) : st.mcTarget)) begin
				next_st.mcCnt = 3'h0;
				next_st.instrEnd = 1'b1;
			end else begin
				next_st.mcCnt = st.mcCnt + 3'h1;
			end
		end

		next_st.awready = !next_st.awHeld && !next_st.bvalid;
		next_st.wready = !next_st.wHeld && !next_st.bvalid;
		next_st.arready = !next_st.rvalid;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st <= '{default: '0, intReset: 1'b1, ioPullup: 1'b1,
				mainOscEnable: 1'b1};
			timerTick <= 1'b0;
			coreTick <= 1'b0;
			adcTick <= 1'b0;
			auxOscEnable <= 1'b0;
		end else begin
			st <= next_st;
			timerTick <= timerPulse;
			coreTick <= corePulse;
			adcTick <= adcFast || adcSlowTick;
			auxOscEnable <= auxEnable;
		end
	end

	assign mainOscEnable = st.mainOscEnable;
	assign intReset      = st.intReset;
	assign ioPullup      = st.ioPullup;
	assign instrEnd      = st.instrEnd;
	assign s_axi_awready = st.awready;
	assign s_axi_wready  = st.wready;
	assign s_axi_bvalid  = st.bvalid;
	assign s_axi_bresp   = st.bresp;
	assign s_axi_arready = st.arready;
	assign s_axi_rvalid  = st.rvalid;
	assign s_axi_rdata   = st.rdata;
	assign s_axi_rresp   = st.rresp;

	a_rst_assert_now: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rstSource |=> st.intReset && st.rstCnt == 11'h0)
		else $error("reset source did not assert internal reset");
	a_rst_release_cnt: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		$fell(st.intReset) |-> $past(st.rstCnt) == 11'h7ff
			&& $past(intTick))
		else $error("internal reset released before full count");
	a_rst_hold_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!extRst_n ##1 !extRst_n |-> st.intReset)
		else $error("internal reset dropped while pin low");
	a_osc_restart: assert property (@(posedge ref_clk) disable iff (!rst_n)
		st.intReset |-> st.mainOscEnable && !st.main_osc_off)
		else $error("main oscillator not restarted by reset");
	a_osc_off_sg: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!st.mainOscEnable |-> st.main_osc_off && safeguardOptionBit)
		else $error("main oscillator stopped without cause");
	a_pullup_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
		st.ioPullup == st.intReset)
		else $error("pull-up state differs from internal reset");
	a_instr_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
		st.instrEnd |-> $past(st.mcCnt) + 3'h1 == st.mcTarget
			|| $past(st.mcCnt) == 3'h0)
		else $error("instruction ended at wrong machine cycle");
	a_axi_bresp: assert property (@(posedge ref_clk) disable iff (!rst_n)
		st.bvalid && !s_axi_bready |=> st.bvalid
			&& $stable(st.bresp))
		else $error("write response dropped before taken");
	a_oscctl_wr: assert property (@(posedge ref_clk) disable iff (!rst_n)
		doWrite && !rstSource && !st.intReset
			&& (awTake ? s_axi_awaddr : st.awAddr) == `CSR_OSCCTL_ADDR
			&& (wTake ? s_axi_wstrb[0] : st.wStrb[0])
		|=> st.main_osc_off == $past(wTake ? s_axi_wdata[0] : st.wData[0]))
		else $error("oscillator control write not stored");
endmodule : csr_top

// ---- test/clock_safeguard_reset_ctrl_tb.sv ----
// Self-checking bench of the clock and reset controller
`timescale 1ns/100ps
`include "csr_cfg.svh"
module clock_safeguard_reset_ctrl_tb;
	import csr_pkg::*;
	localparam int MAINP = 5;
	localparam int AUXP  = 25;
	logic ref_clk, rst_n, mainOscIn, auxOscIn, safeguardOptionBit;
	logic mainOscEnable, auxOscEnable, extRst_n, porReq, wdgRstReq;
	logic intReset, ioPullup, timerTick, coreTick, adcTick, instrEnd;
	logic mainStop, mainFast;
	csr_ilen_t   instrLen;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd, rnd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [31:0] seed;
	int          err_total, n_compared, cyc, c, g;

	csr_top u_csr_top (.ref_clk, .rst_n, .mainOscIn, .auxOscIn,
		.safeguardOptionBit, .mainOscEnable, .auxOscEnable, .extRst_n,
		.porReq, .wdgRstReq, .intReset, .ioPullup, .instrLen, .timerTick,
		.coreTick, .adcTick, .instrEnd, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	csr_osc_model u_csr_osc_model (.mainOscEnable, .auxOscEnable,
		.mainStop, .mainFast, .mainOscIn, .auxOscIn);

	always #20 ref_clk = ~ref_clk;

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	// Reset release window in ref_clk cycles for a given tick period
	function automatic logic inWin(input int n, input int per);
		return n >= (`CSR_RST_DELAY - 1) * per &&
			n <= `CSR_RST_DELAY * per + 8;
	endfunction : inWin

	function automatic int ilen(input int i);
		return (i == 0) ? 2 : (i == 1) ? 4 : 5;
	endfunction : ilen

	function automatic logic pk(input int s);
		case (s)
			0: return timerTick;
			1: return coreTick;
			2: return adcTick;
			default: return instrEnd;
		endcase
	endfunction : pk

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] v);
		n_compared++;
		if (v !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, v);
			err_total++;
		end
	endtask : chk

	task automatic axw(input logic [11:0] a, input logic [31:0] d,
		output logic [1:0] r);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge ref_clk);
	endtask : axw

	task automatic axr(input logic [11:0] a, output logic [31:0] d,
		output logic [1:0] r);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge ref_clk);
	endtask : axr

	// Cycles between two consecutive pulses of the chosen output
	task automatic gap(input int s, output int n);
		n = 0;
		do @(posedge ref_clk); while (pk(s) !== 1'b1);
		do begin
			@(posedge ref_clk);
			n++;
		end while (pk(s) !== 1'b1);
	endtask : gap

	task automatic waitRel(output int n);
		n = 0;
		while (intReset !== 1'b0) begin
			@(posedge ref_clk);
			n++;
		end
	endtask : waitRel

	task automatic waitAux(input logic v);
		int k;
		k = 0;
		while (auxOscEnable !== v && k < 80) begin
			@(posedge ref_clk);
			k++;
		end
		chk("auxOscEnable", {31'h0, v}, {31'h0, auxOscEnable});
	endtask : waitAux

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up

	// Ceiling well above the roughly 56k cycles the sequence needs
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 90000) begin
			err_total++;
			wrap_up();
		end
	end

	initial begin
		ref_clk = 1'b0; rst_n = 1'b0; safeguardOptionBit = 1'b0;
		extRst_n = 1'b1; porReq = 1'b0; wdgRstReq = 1'b0;
		mainStop = 1'b0; mainFast = 1'b0; instrLen = CSR_ILEN_2;
		s_axi_awaddr = 12'h000; s_axi_araddr = 12'h000;
		s_axi_wdata = 32'h0; s_axi_wstrb = 4'h1;
		s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
		seed = 32'h00008849; err_total = 0; n_compared = 0; cyc = 0;
		repeat (9) @(posedge ref_clk);
		chk("intReset", 32'h1, intReset);
		chk("ioPullup", 32'h1, ioPullup);
		chk("mainOscEnable", 32'h1, mainOscEnable);
		chk("timerTick", 32'h0, timerTick);
		@(posedge ref_clk);
		rst_n <= 1'b1;
		waitRel(c);
		chk("releaseWindow", 32'h1, inWin(c, MAINP));
		axr(`CSR_OSCCTL_ADDR, rd, rs);
		chk("oscctlReset", 32'h0, rd);
		axw(`CSR_OSCCTL_ADDR, 32'h1, rs);
		axr(`CSR_OSCCTL_ADDR, rd, rs);
		chk("oscctlRead", 32'h1, rd);
		repeat (60) @(posedge ref_clk);
		chk("mainOscEnable", 32'h1, mainOscEnable);
		axw(`CSR_OSCCTL_ADDR, 32'h0, rs);
		$display("test option off done");
		safeguardOptionBit <= 1'b1;
		for (int s = 0; s < 3; s++) begin
			rnd = xs();
			repeat (rnd[2:0] + 1) @(posedge ref_clk);
			if (s == 0) extRst_n <= 1'b0;
			else if (s == 1) porReq <= 1'b1;
			else wdgRstReq <= 1'b1;
			repeat (s == 0 ? 100 : 1) @(posedge ref_clk);
			extRst_n <= 1'b1;
			porReq <= 1'b0;
			wdgRstReq <= 1'b0;
			@(posedge ref_clk);
			chk("intReset", 32'h1, intReset);
			chk("ioPullup", 32'h1, ioPullup);
			waitRel(c);
			chk("releaseWindow", 32'h1, inWin(c, MAINP));
		end
		$display("test reset sources done");
		gap(0, g);
		chk("timerGap", `CSR_DIV_TIMER * MAINP, g);
		gap(1, g);
		chk("coreGap", `CSR_DIV_CORE * MAINP, g);
		gap(2, g);
		chk("adcFastGap", `CSR_DIV_ADC_FAST * MAINP, g);
		axw(`CSR_CLKCTL_ADDR, 32'h1, rs);
		gap(2, g);
		gap(2, g);
		chk("adcSlowGap", `CSR_DIV_ADC_SLOW * MAINP, g);
		axr(`CSR_CLKCTL_ADDR, rd, rs);
		chk("adcSlow", 32'h1, rd[0]);
		for (int i = 0; i < 3; i++) begin
			instrLen <= csr_ilen_t'(i);
			gap(3, g);
			gap(3, g);
			chk("instrGap", ilen(i) * `CSR_DIV_CORE * MAINP, g);
		end
		$display("test dividers done");
		axw(`CSR_OSCCTL_ADDR, 32'h1, rs);
		repeat (2) @(posedge ref_clk);
		chk("mainOscEnable", 32'h0, mainOscEnable);
		waitAux(1'b1);
		gap(0, g);
		gap(0, g);
		chk("auxTimerGap", `CSR_DIV_TIMER * AUXP, g);
		axr(`CSR_CLKCTL_ADDR, rd, rs);
		chk("auxStatus", 32'h1, rd[`CSR_ST_AUX_BIT]);
		axw(`CSR_OSCCTL_ADDR, 32'h0, rs);
		waitAux(1'b0);
		chk("mainOscEnable", 32'h1, mainOscEnable);
		mainStop <= 1'b1;
		waitAux(1'b1);
		mainStop <= 1'b0;
		waitAux(1'b0);
		$display("test fail-over done");
		axw(`CSR_OSCCTL_ADDR, 32'h1, rs);
		repeat (40) @(posedge ref_clk);
		wdgRstReq <= 1'b1;
		@(posedge ref_clk);
		wdgRstReq <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk("mainOscEnable", 32'h1, mainOscEnable);
		waitRel(c);
		axr(`CSR_OSCCTL_ADDR, rd, rs);
		chk("oscctlAfterReset", 32'h0, rd);
		mainFast <= 1'b1;
		gap(0, g);
		gap(0, g);
		chk("capGap", 32'h1, g >= `CSR_DIV_TIMER * `CSR_SG_MIN_CYC);
		mainFast <= 1'b0;
		$display("test restart and cap done");
		for (int i = 0; i < 3; i++) begin
			rnd = xs();
			if (rnd[7:0] == 8'hdb || rnd[7:0] == 8'hdc) rnd[7:0] = 8'h10;
			axr({2'b00, rnd[7:0], 2'b00}, rd, rs);
			chk("unmappedResp", `CSR_RESP_SLVERR, rs);
			chk("unmappedData", 32'h0, rd);
			axw({2'b00, rnd[7:0], 2'b00}, xs(), rs);
			chk("unmappedWrite", `CSR_RESP_SLVERR, rs);
		end
		$display("test unmapped done");
		wrap_up();
	end
endmodule : clock_safeguard_reset_ctrl_tb

// ---- test/csr_osc_model.sv ----
// Behavioural main and auxiliary oscillators facing the controller
`timescale 1ns/100ps
module csr_osc_model #(
	parameter int MAIN_HALF = 100,
	parameter int FAST_HALF = 40,
	parameter int AUX_HALF  = 500
) (
	// Enables from the controller
	input  wire logic mainOscEnable,
	input  wire logic auxOscEnable,
	// Faults commanded by the bench
	input  wire logic mainStop,
	input  wire logic mainFast,
	// Oscillator levels
	output logic      mainOscIn,
	output logic      auxOscIn
);
	// Stopped oscillators rest low; 3 ns restart keeps edges off ref_clk
	initial begin
		mainOscIn = 1'b0;
		forever begin
			if (mainOscEnable === 1'b1 && mainStop === 1'b0) begin
				#(mainFast ? FAST_HALF : MAIN_HALF);
				mainOscIn = ~mainOscIn;
			end else begin
				mainOscIn = 1'b0;
				@(mainOscEnable or mainStop);
				#3;
			end
		end
	end

	initial begin
		auxOscIn = 1'b0;
		forever begin
			if (auxOscEnable === 1'b1) begin
				#(AUX_HALF);
				auxOscIn = ~auxOscIn;
			end else begin
				auxOscIn = 1'b0;
				@(auxOscEnable);
				#3;
			end
		end
	end
endmodule : csr_osc_model
